// ===== pkg/lfws_consts.svh
// Constants of the LF wakeup protocol sequencer.
// Assumes a 40 MHz system clock and a 32768 Hz RTC time base.
// Contract
// - Wake release command ends wake, back listening
// - Timeout code times 50 ms, code 0 none
// - Correlation off: carrier alone raises wake
// - Timeout counts from wake rise, then listen
// - ON/OFF mode: burst limit at least 10 ms
// - Burst too long: drop, count false wakeup
// - Compare stream against both pattern bytes
// - No decoder: wake one bit after pattern
// - After pattern wake, command or timeout releases
// - Decoder mode: wake, decode data, output clock
// - Decoder and ON/OFF mode never together
// - Failed correlation counts one false wakeup
// - Decoder enabled: false wakeups not counted
// - Bit period 4 to 32 RTC periods
// - No preamble within 16 bits: listen, count
`ifndef LFWS_CONSTS_SVH
`define LFWS_CONSTS_SVH
`define LFWS_CLK_HZ 40000000
`define LFWS_RTC_HZ 32768
`define LFWS_RTC_DIV (`LFWS_CLK_HZ / `LFWS_RTC_HZ)
`define LFWS_MIN_BURST_US 550
`define LFWS_MIN_BURST_RTC \
    ((`LFWS_MIN_BURST_US * `LFWS_RTC_HZ + 999999) / 1000000)
`define LFWS_ONOFF_US 10000
`define LFWS_ONOFF_RTC ((`LFWS_ONOFF_US * `LFWS_RTC_HZ) / 1000000)
`define LFWS_TO_STEP_US 50000
`define LFWS_TO_STEP_RTC ((`LFWS_TO_STEP_US * `LFWS_RTC_HZ) / 1000000)
`define LFWS_PRE_LIMIT 6'h10
`define LFWS_SEQ_LIMIT 6'h28
`define LFWS_PRE_BITS 3'h4
`define LFWS_BIT_MIN 6'h04
`define LFWS_OFF_MAIN 8'h00
`define LFWS_OFF_PAT_HI 8'h04
`define LFWS_OFF_PAT_LO 8'h08
`define LFWS_OFF_TIMING 8'h0c
`define LFWS_OFF_COUNT 8'h10
`define LFWS_OFF_STATUS 8'h14
`define LFWS_OFF_CMD 8'h18
`define LFWS_BIT_CORR 1
`define LFWS_BIT_DEC 3
`define LFWS_BIT_ONOFF 5
`define LFWS_RST_MAIN 8'h02
`define LFWS_RST_PAT_HI 8'h69
`define LFWS_RST_PAT_LO 8'h96
`define LFWS_RST_TIMING 8'h03
`endif

// ===== pkg/lfws_pkg.sv
// Types of the LF wakeup protocol sequencer.
// Assumes nothing beyond the constants header.
package lfws_pkg;
    typedef enum logic [2:0] {
        S_LISTEN, S_BURST, S_PREAMB, S_PATTERN, S_WAKEDLY, S_WAKE
    } lfws_state_t;
endpackage

// ===== tb/lfws_lf_tx.sv
// Remote LF transmitter: carrier bursts and ON/OFF modulated bits.
// Assumes one RTC tick every TICK cycles of the bench clock.
`timescale 1ns/10ps
module lfws_lf_tx #(
    parameter int TICK = 4
) (
    input wire logic clk_i,
    output logic carrier_o,
    output logic data_o
);
    logic busy = 1'h0;
    logic level = 1'h0;
    logic tog = 1'h0;
    ////////////////////////////////////////////////////////////////////////
    // Undriven data line toggles, so a stale level never passes as data
    always @(posedge clk_i) begin
        tog <= ~tog;
    end
    assign carrier_o = busy & level;
    assign data_o = busy ? level : tog;
    ////////////////////////////////////////////////////////////////////////
    // Hold one level for a whole number of RTC ticks
    task automatic send(input logic c, input int ticks);
        @(posedge clk_i);
        busy <= 1'h1;
        level <= c;
        repeat (ticks * TICK - 1) @(posedge clk_i);
    endtask
    // Most significant bit first, per ticks to a bit
    task automatic bits(input logic [39:0] v, input int n, input int per);
        for (int i = n - 1; i >= 0; i--) begin
            send(v[i], per);
        end
    endtask
    task automatic idle;
        @(posedge clk_i);
        busy <= 1'h0;
    endtask
endmodule // lfws_lf_tx

// ===== tb/lfws_sequencer_tb_top.sv
// Bench of the wakeup sequencer: register bus and over-air frames.
// Assumes the transmitter model and an RTC tick cut to 4 clocks.
`timescale 1ns/10ps
`include "lfws_consts.svh"
module lfws_sequencer_tb_top;
    localparam int TK = 4;
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic carrier, data, wake, ddat, dclk;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, cnt;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int error_cnt = 0;
    int comparisons = 0;
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    lfws_sequencer #(.RTC_DIV(TK)) dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .carrier_i(carrier),
        .data_i(data), .wake_o(wake), .dec_data_o(ddat), .dec_clk_o(dclk),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready)
    );
    lfws_lf_tx #(.TICK(TK)) tx_u (
        .clk_i(clk_i), .carrier_o(carrier), .data_o(data)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic chkb(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask
    task automatic test_done;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic expire;
        check(32'h0, 32'h1);
        test_done();
    endtask
    // Address and data offered together; bready held until the answer
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] er);
        int n;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_i);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
            n++;
        end while (bvalid !== 1'h1 && n < 60);
        if (n >= 60) expire();
        bready <= 1'h0;
        check({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input logic [1:0] er);
        int n;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_i);
            if (arready === 1'h1) arvalid <= 1'h0;
            n++;
        end while (rvalid !== 1'h1 && n < 60);
        if (n >= 60) expire();
        rready <= 1'h0;
        check(rdata, {24'h0, e});
        check({30'h0, rresp}, {30'h0, er});
    endtask
    task automatic cnt_chk(input logic [7:0] inc);
        cnt = cnt + inc;
        rd(`LFWS_OFF_COUNT, cnt, 2'h0);
    endtask
    // Bounded wait for wake (sel 0) or recovered clock (sel 1) at a level
    task automatic ww(input logic sel, input logic lvl, input int lim,
        output int n);
        n = 0;
        while ((sel ? dclk : wake) !== lvl && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        // A level never reached is a hang, not a late answer
        if ((sel ? dclk : wake) !== lvl) expire();
    endtask
    task automatic frame(input int bt, input logic dec, input logic [15:0] p);
        tx_u.send(1'h1, bt);
        if (dec) tx_u.send(1'h0, 4);
        tx_u.bits({16'h0, dec ? 8'haa : 8'h55, p}, 24, 4);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic s_regs;
        rd(`LFWS_OFF_MAIN, `LFWS_RST_MAIN, 2'h0);
        rd(`LFWS_OFF_PAT_HI, `LFWS_RST_PAT_HI, 2'h0);
        rd(`LFWS_OFF_PAT_LO, `LFWS_RST_PAT_LO, 2'h0);
        rd(`LFWS_OFF_TIMING, `LFWS_RST_TIMING, 2'h0);
        rd(8'h40, 8'h00, 2'h2);
        wr(8'h40, 8'h5a, 2'h2);
        cnt = 8'h00;
        cnt_chk(8'h00);
        cnt = 8'hfe;
        wr(`LFWS_OFF_COUNT, cnt, 2'h0);
        cnt_chk(8'h00);
        cnt_chk(8'h00);
    endtask
    task automatic s_carrier;
        int n;
        wr(`LFWS_OFF_MAIN, 8'h00, 2'h0);
        wr(`LFWS_OFF_TIMING, 8'h23, 2'h0);
        tx_u.send(1'h1, 16);
        tx_u.idle();
        repeat (40) @(posedge clk_i);
        chkb(wake, 1'h0);
        fork
            begin
                tx_u.send(1'h1, 40);
                tx_u.idle();
            end
        join_none
        ww(1'h0, 1'h1, 200, n);
        chkb(n >= 76 && n <= 92, 1'h1);
        ww(1'h0, 1'h0, 7000, n);
        chkb(n >= 6546 && n <= 6560, 1'h1);
    endtask
    task automatic s_release;
        int n;
        wr(`LFWS_OFF_TIMING, `LFWS_RST_TIMING, 2'h0);
        tx_u.send(1'h1, 30);
        tx_u.idle();
        repeat (300) @(posedge clk_i);
        chkb(wake, 1'h1);
        rd(`LFWS_OFF_STATUS, 8'h03, 2'h0);
        wr(`LFWS_OFF_CMD, 8'h01, 2'h0);
        ww(1'h0, 1'h0, 8, n);
        chkb(wake, 1'h0);
    endtask
    task automatic s_pattern;
        int n;
        wr(`LFWS_OFF_MAIN, `LFWS_RST_MAIN, 2'h0);
        frame(30, 1'h0, {`LFWS_RST_PAT_HI, `LFWS_RST_PAT_LO});
        tx_u.idle();
        chkb(wake, 1'h0);
        ww(1'h0, 1'h1, 40, n);
        chkb(n >= 10 && n <= 30, 1'h1);
        wr(`LFWS_OFF_CMD, 8'h02, 2'h0);
        ww(1'h0, 1'h0, 8, n);
        chkb(wake, 1'h0);
        cnt_chk(8'h00);
    endtask
    task automatic s_fail;
        int n;
        frame(30, 1'h0, 16'h1234);
        tx_u.idle();
        repeat (400) @(posedge clk_i);
        chkb(wake, 1'h0);
        cnt_chk(8'h01);
        frame(70, 1'h0, {`LFWS_RST_PAT_HI, `LFWS_RST_PAT_LO});
        tx_u.idle();
        repeat (400) @(posedge clk_i);
        chkb(wake, 1'h0);
        cnt_chk(8'h01);
        tx_u.send(1'h1, 30);
        tx_u.bits(40'h0, 24, 4);
        tx_u.idle();
        cnt_chk(8'h01);
        wr(`LFWS_OFF_MAIN, 8'h22, 2'h0);
        frame(70, 1'h0, {`LFWS_RST_PAT_HI, `LFWS_RST_PAT_LO});
        tx_u.idle();
        ww(1'h0, 1'h1, 40, n);
        chkb(wake, 1'h1);
        wr(`LFWS_OFF_CMD, 8'h01, 2'h0);
    endtask
    task automatic s_dec;
        int n;
        wr(`LFWS_OFF_MAIN, 8'h0a, 2'h0);
        frame(30, 1'h1, {`LFWS_RST_PAT_HI, `LFWS_RST_PAT_LO});
        fork
            begin
                tx_u.bits(40'h9, 4, 4);
                tx_u.idle();
            end
        join_none
        ww(1'h0, 1'h1, 12, n);
        chkb(wake, 1'h1);
        ww(1'h1, 1'h1, 60, n);
        chkb(ddat, 1'h1);
        ww(1'h1, 1'h0, 40, n);
        ww(1'h1, 1'h1, 40, n);
        chkb(ddat, 1'h0);
        wr(`LFWS_OFF_CMD, 8'h02, 2'h0);
        ww(1'h0, 1'h0, 8, n);
        chkb(wake, 1'h0);
        frame(30, 1'h1, 16'h1234);
        tx_u.idle();
        repeat (400) @(posedge clk_i);
        cnt_chk(8'h00);
        wr(`LFWS_OFF_MAIN, 8'h2a, 2'h0);
        frame(30, 1'h0, 16'h1234);
        tx_u.idle();
        chkb(dclk, 1'h0);
        repeat (400) @(posedge clk_i);
        cnt_chk(8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'h0;
        s_regs();
        s_carrier();
        s_release();
        s_pattern();
        s_fail();
        s_dec();
        test_done();
    end
endmodule // lfws_sequencer_tb_top

// ===== verilog/lfws_sequencer.sv
// Wakeup protocol sequencer with AXI4-Lite register slave.
// Assumes carrier and data levels from an asynchronous front end.
`timescale 1ns/10ps
`include "lfws_consts.svh"
module lfws_sequencer import lfws_pkg::*; #(
    parameter int RTC_DIV = `LFWS_RTC_DIV
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic carrier_i,
    input wire logic data_i,
    output logic wake_o,
    output logic dec_data_o,
    output logic dec_clk_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
////////////////////////////////////////////////////////////////////////////
// Input synchronisers and RTC tick
logic [1:0] car_sync_reg, dat_sync_reg;
logic [15:0] div_reg, div_next;
logic rtc_tick;
always_comb begin
    div_next = (div_reg == 16'(RTC_DIV - 1)) ? 16'h0000 : div_reg + 16'h0001;
end
always_ff @(posedge clk_i) begin
    if (reset_i) begin
        car_sync_reg <= 2'h0;
        dat_sync_reg <= 2'h0;
        div_reg <= 16'h0000;
    end else begin
        car_sync_reg <= {car_sync_reg[0], carrier_i};
        dat_sync_reg <= {dat_sync_reg[0], data_i};
        div_reg <= div_next;
    end
end
assign rtc_tick = (div_reg == 16'(RTC_DIV - 1));
wire carrier_s = car_sync_reg[1];
wire data_s = dat_sync_reg[1];
////////////////////////////////////////////////////////////////////////////
// Register slave
logic [7:0] main_config_reg, main_config_next;
logic [7:0] pattern_byte_high, pattern_byte_high_next;
logic [7:0] pattern_byte_low, pattern_byte_low_next;
logic [7:0] timing_config_reg, timing_config_next;
logic [7:0] spurious_event_count_reg, spurious_event_count_next;
logic awready_reg, awready_next, bvalid_reg, bvalid_next;
logic arready_reg, arready_next, rvalid_reg, rvalid_next;
logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
logic [31:0] rdata_reg, rdata_next;
logic cnt_wr, cmd_clr;
lfws_state_t state_reg, state_next;
logic wake_reg;
wire wr_go = awready_reg && s_axi_awvalid_i && s_axi_wvalid_i;
wire wr_lo = wr_go && s_axi_wstrb_i[0];
always_comb begin
    main_config_next = main_config_reg;
    pattern_byte_high_next = pattern_byte_high;
    pattern_byte_low_next = pattern_byte_low;
    timing_config_next = timing_config_reg;
    awready_next = 1'b0;
    arready_next = 1'b0;
    bvalid_next = bvalid_reg && !s_axi_bready_i;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready_i;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    cnt_wr = 1'b0;
    cmd_clr = 1'b0;
    // Address and data are taken together; simpler and legal
    if (s_axi_awvalid_i && s_axi_wvalid_i && !awready_reg && !bvalid_reg)
        awready_next = 1'b1;
    if (wr_go) begin
        bvalid_next = 1'b1;
        bresp_next = 2'b00;
        unique case (s_axi_awaddr_i)
            `LFWS_OFF_MAIN: if (wr_lo) main_config_next = s_axi_wdata_i[7:0];
            `LFWS_OFF_PAT_HI:
                if (wr_lo) pattern_byte_high_next = s_axi_wdata_i[7:0];
            `LFWS_OFF_PAT_LO:
                if (wr_lo) pattern_byte_low_next = s_axi_wdata_i[7:0];
            `LFWS_OFF_TIMING: if (wr_lo) timing_config_next = s_axi_wdata_i[7:0];
            `LFWS_OFF_COUNT: cnt_wr = wr_lo;
            `LFWS_OFF_STATUS: ;
            `LFWS_OFF_CMD: cmd_clr = wr_lo && |s_axi_wdata_i[1:0];
            default: bresp_next = 2'b10;
        endcase
    end
    if (s_axi_arvalid_i && !arready_reg && !rvalid_reg)
        arready_next = 1'b1;
    if (arready_reg && s_axi_arvalid_i) begin
        rvalid_next = 1'b1;
        rresp_next = 2'b00;
        rdata_next = 32'h0000_0000;
        unique case (s_axi_araddr_i)
            `LFWS_OFF_MAIN: rdata_next[7:0] = main_config_reg;
            `LFWS_OFF_PAT_HI: rdata_next[7:0] = pattern_byte_high;
            `LFWS_OFF_PAT_LO: rdata_next[7:0] = pattern_byte_low;
            `LFWS_OFF_TIMING: rdata_next[7:0] = timing_config_reg;
            `LFWS_OFF_COUNT: rdata_next[7:0] = spurious_event_count_reg;
            `LFWS_OFF_STATUS:
                rdata_next[1:0] = {state_reg != S_LISTEN, wake_reg};
            `LFWS_OFF_CMD: ;
            default: rresp_next = 2'b10;
        endcase
    end
end
always_ff @(posedge clk_i) begin
    if (reset_i) begin
        main_config_reg <= `LFWS_RST_MAIN;
        pattern_byte_high <= `LFWS_RST_PAT_HI;
        pattern_byte_low <= `LFWS_RST_PAT_LO;
        timing_config_reg <= `LFWS_RST_TIMING;
        awready_reg <= 1'b0;
        bvalid_reg <= 1'b0;
        bresp_reg <= 2'b00;
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b0;
        rresp_reg <= 2'b00;
        rdata_reg <= 32'h0000_0000;
    end else begin
        main_config_reg <= main_config_next;
        pattern_byte_high <= pattern_byte_high_next;
        pattern_byte_low <= pattern_byte_low_next;
        timing_config_reg <= timing_config_next;
        awready_reg <= awready_next;
        bvalid_reg <= bvalid_next;
        bresp_reg <= bresp_next;
        arready_reg <= arready_next;
        rvalid_reg <= rvalid_next;
        rresp_reg <= rresp_next;
        rdata_reg <= rdata_next;
    end
end
////////////////////////////////////////////////////////////////////////////
// Derived settings
wire corr_en = main_config_reg[`LFWS_BIT_CORR];
wire onoff_en = main_config_reg[`LFWS_BIT_ONOFF];
// ON/OFF mode overrides the decoder
wire dec_eff = main_config_reg[`LFWS_BIT_DEC] && !onoff_en;
wire [5:0] bit_raw = {1'b0, timing_config_reg[4:0]} + 6'h01;
wire [5:0] bitper = (bit_raw < `LFWS_BIT_MIN) ? `LFWS_BIT_MIN : bit_raw;
wire [9:0] lim16 = {bitper, 4'h0};
wire [9:0] burst_lim = (onoff_en && lim16 < 10'(`LFWS_ONOFF_RTC)) ?
    10'(`LFWS_ONOFF_RTC) : lim16;
wire [2:0] to_sel = timing_config_reg[7:5];
wire [13:0] to_lim = 14'(to_sel * `LFWS_TO_STEP_RTC);
wire [15:0] pattern = {pattern_byte_high, pattern_byte_low};
////////////////////////////////////////////////////////////////////////////
// Protocol sequencer
logic wake_next, dec_data_reg, dec_data_next, dec_clk_reg, dec_clk_next;
logic [4:0] ph_reg, ph_next;
logic [5:0] bit_cnt_reg, bit_cnt_next;
logic [9:0] burst_reg, burst_next;
logic [13:0] to_cnt_reg, to_cnt_next;
logic [15:0] sh_reg, sh_next;
logic last_reg, last_next, half_reg, half_next, first_reg, first_next;
logic [2:0] alt_reg, alt_next;
logic fail;
wire bit_end = rtc_tick && (ph_reg == 5'(bitper - 6'h01));
wire [15:0] sh_in = {sh_reg[14:0], data_s};
always_comb begin
    state_next = state_reg;
    ph_next = ph_reg;
    bit_cnt_next = bit_cnt_reg;
    burst_next = burst_reg;
    to_cnt_next = to_cnt_reg;
    sh_next = sh_reg;
    last_next = last_reg;
    alt_next = alt_reg;
    half_next = half_reg;
    first_next = first_reg;
    dec_data_next = dec_data_reg;
    dec_clk_next = dec_clk_reg && dec_eff;
    fail = 1'b0;
    if (rtc_tick)
        ph_next = bit_end ? 5'h00 : ph_reg + 5'h01;
    if (bit_end) begin
        sh_next = sh_in;
        bit_cnt_next = bit_cnt_reg + 6'h01;
    end
    unique case (state_reg)
        S_LISTEN: if (carrier_s) begin
            state_next = S_BURST;
            burst_next = 10'h000;
        end
        S_BURST: begin
            if (rtc_tick && carrier_s && burst_reg != 10'h3ff)
                burst_next = burst_reg + 10'h001;
            if (!corr_en && burst_reg >= 10'(`LFWS_MIN_BURST_RTC)) begin
                state_next = S_WAKE;
            end else if (corr_en && burst_reg > burst_lim) begin
                fail = 1'b1;
                state_next = S_LISTEN;
            end else if (!carrier_s) begin
                // Too short a burst never passed frequency detection
                if (corr_en && burst_reg >= 10'(`LFWS_MIN_BURST_RTC)) begin
                    state_next = S_PREAMB;
                    ph_next = 5'h00;
                    bit_cnt_next = 6'h00;
                    alt_next = 3'h0;
                end else begin
                    state_next = S_LISTEN;
                end
            end
        end
        S_PREAMB: if (bit_end) begin
            last_next = data_s;
            alt_next = (alt_reg == 3'h0 || data_s != last_reg) ?
                alt_reg + 3'h1 : 3'h1;
            if (alt_next >= `LFWS_PRE_BITS) begin
                state_next = S_PATTERN;
            end else if (bit_cnt_next >= `LFWS_PRE_LIMIT) begin
                fail = 1'b1;
                state_next = S_LISTEN;
            end
        end
        S_PATTERN: if (bit_end) begin
            if (sh_in == pattern) begin
                state_next = dec_eff ? S_WAKE : S_WAKEDLY;
                half_next = 1'b0;
            end else if (bit_cnt_next >= `LFWS_SEQ_LIMIT) begin
                fail = 1'b1;
                state_next = S_LISTEN;
            end
        end
        S_WAKEDLY: begin
            if (cmd_clr)
                state_next = S_LISTEN;
            else if (bit_end)
                state_next = S_WAKE;
        end
        S_WAKE: begin
            if (rtc_tick)
                to_cnt_next = to_cnt_reg + 14'h0001;
            if (cmd_clr) begin
                state_next = S_LISTEN;
            end else if (to_sel != 3'h0 && rtc_tick &&
                         to_cnt_next >= to_lim) begin
                state_next = S_LISTEN;
            end
            if (dec_eff && bit_end) begin
                half_next = !half_reg;
                if (!half_reg) begin
                    first_next = data_s;
                    dec_clk_next = 1'b0;
                end else begin
                    dec_data_next = first_reg;
                    dec_clk_next = 1'b1;
                end
            end
        end
        default: state_next = S_LISTEN;
    endcase
    if (state_next == S_WAKE && state_reg != S_WAKE)
        to_cnt_next = 14'h0000;
    wake_next = (state_next == S_WAKE);
    spurious_event_count_next = cnt_wr ? s_axi_wdata_i[7:0] :
        spurious_event_count_reg;
    if (fail && !dec_eff)
        spurious_event_count_next = spurious_event_count_next + 8'h01;
end
always_ff @(posedge clk_i) begin
    if (reset_i) begin
        state_reg <= S_LISTEN;
        wake_reg <= 1'b0;
        dec_data_reg <= 1'b0;
        dec_clk_reg <= 1'b0;
        ph_reg <= 5'h00;
        bit_cnt_reg <= 6'h00;
        burst_reg <= 10'h000;
        to_cnt_reg <= 14'h0000;
        sh_reg <= 16'h0000;
        last_reg <= 1'b0;
        alt_reg <= 3'h0;
        half_reg <= 1'b0;
        first_reg <= 1'b0;
        spurious_event_count_reg <= 8'h00;
    end else begin
        state_reg <= state_next;
        wake_reg <= wake_next;
        dec_data_reg <= dec_data_next;
        dec_clk_reg <= dec_clk_next;
        ph_reg <= ph_next;
        bit_cnt_reg <= bit_cnt_next;
        burst_reg <= burst_next;
        to_cnt_reg <= to_cnt_next;
        sh_reg <= sh_next;
        last_reg <= last_next;
        alt_reg <= alt_next;
        half_reg <= half_next;
        first_reg <= first_next;
        spurious_event_count_reg <= spurious_event_count_next;
    end
end
assign wake_o = wake_reg;
assign dec_data_o = dec_data_reg;
assign dec_clk_o = dec_clk_reg;
assign s_axi_awready_o = awready_reg;
assign s_axi_wready_o = awready_reg;
assign s_axi_bvalid_o = bvalid_reg;
assign s_axi_bresp_o = bresp_reg;
assign s_axi_arready_o = arready_reg;
assign s_axi_rvalid_o = rvalid_reg;
assign s_axi_rresp_o = rresp_reg;
assign s_axi_rdata_o = rdata_reg;
////////////////////////////////////////////////////////////////////////////
// Checks
default clocking @(posedge clk_i); endclocking
default disable iff (reset_i);
release_cmd_a: assert property (
    cmd_clr && state_reg == S_WAKE |=> !wake_o && state_reg == S_LISTEN)
    else $error("wake not released by command");
timeout_bound_a: assert property (
    state_reg == S_WAKE && to_sel != 3'h0 |-> to_cnt_reg < to_lim)
    else $error("wake outlived its timeout");
timeout_start_a: assert property (
    $rose(wake_o) |-> to_cnt_reg == 14'h0000)
    else $error("timeout count not restarted at wake");
carrier_wake_a: assert property (
    state_reg == S_BURST && !corr_en &&
    burst_reg >= 10'(`LFWS_MIN_BURST_RTC) |=> wake_o)
    else $error("carrier-only wake missing");
burst_false_a: assert property (
    state_reg == S_BURST && corr_en && burst_reg > burst_lim &&
    !dec_eff && !cnt_wr |=> spurious_event_count_reg ==
    $past(spurious_event_count_reg) + 8'h01 && state_reg == S_LISTEN)
    else $error("long burst not counted");
bit_delay_a: assert property (
    $rose(wake_o) && corr_en && !dec_eff |->
    $past(state_reg) == S_WAKEDLY)
    else $error("wake without one bit delay");
dec_quiet_a: assert property (
    dec_eff && !cnt_wr |=> $stable(spurious_event_count_reg))
    else $error("false wakeup counted in decoder mode");
onoff_clock_a: assert property (
    onoff_en |=> !dec_clk_o)
    else $error("decoder clock active in ON/OFF mode");
preamble_limit_a: assert property (
    state_reg == S_PREAMB |-> bit_cnt_reg < `LFWS_PRE_LIMIT)
    else $error("preamble search overran");
pattern_hit_a: assert property (
    state_reg == S_PATTERN && bit_end && sh_in == pattern |=>
    state_reg == S_WAKE || state_reg == S_WAKEDLY)
    else $error("pattern match ignored");
pattern_wake_c: cover property (state_reg == S_WAKEDLY ##1 $rose(wake_o));
false_count_c: cover property (fail && !dec_eff);
timeout_exit_c: cover property (state_reg == S_WAKE && !cmd_clr
    ##1 state_reg == S_LISTEN);
decoder_clock_c: cover property ($rose(dec_clk_o));
endmodule // lfws_sequencer
